// [rtl/bkl_pkg.sv]
// bkl_pkg: constants and types of the backlight control register bank
// assumes: 8-bit register space reached over a two-wire serial slave
package bkl_pkg;
    localparam int unsigned AW = 8;
    localparam int unsigned DW = 8;
    localparam logic [6:0] SLAVE_ADDR = 7'h2c;
    // register offsets
    localparam logic [7:0] ADDR_LEVEL   = 8'h00;
    localparam logic [7:0] ADDR_SETUP   = 8'h01;
    localparam logic [7:0] ADDR_FAULT   = 8'h02;
    localparam logic [7:0] ADDR_IDENT   = 8'h03;
    localparam logic [7:0] ADDR_DIRECT  = 8'h04;
    localparam logic [7:0] ADDR_TEMP_HI = 8'h05;
    localparam logic [7:0] ADDR_TEMP_LO = 8'h06;
    localparam logic [7:0] ADDR_NVM     = 8'h72;
    // field positions
    localparam int unsigned ON_BIT      = 0;
    localparam int unsigned SRC_LSB     = 1;
    localparam int unsigned SRC_W       = 2;
    localparam int unsigned OPEN_BIT    = 7;
    localparam int unsigned SHORT_BIT   = 6;
    localparam int unsigned ANYLED_BIT  = 3;
    localparam int unsigned OCP_BIT     = 2;
    localparam int unsigned TSD_BIT     = 1;
    localparam int unsigned LOW_SUPPLY_FLAG_BIT    = 0;
    localparam int unsigned DIRECT_LSB  = 1;
    localparam int unsigned DIRECT_W    = 6;
    localparam int unsigned NVM_IDLE_BIT = 7;
    localparam int unsigned NVM_CMD_W   = 3;
    localparam int unsigned TEMP_W      = 11;
    localparam int unsigned TEMP_LO_W   = 3;
    // reset values
    localparam logic [7:0] LEVEL_RST  = 8'h00;
    localparam logic [7:0] SETUP_RST  = 8'h00;
    localparam logic [7:0] FAULT_RST  = 8'h00;
    localparam logic [7:0] DIRECT_RST = 8'h00;
    // duty measurement window, log2 of cycles
    localparam int unsigned MEAS_WIN_W = 16;

    typedef enum logic [1:0] {
        SRC_PIN_A = 2'b00,
        SRC_PIN_B = 2'b01,
        SRC_REG   = 2'b10,
        SRC_PASS  = 2'b11
    } bkl_src_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b011,
        ST_RXB  = 3'b010,
        ST_RACK = 3'b110,
        ST_TXB  = 3'b111,
        ST_TACK = 3'b101
    } bkl_i2c_st_t;
endpackage

// [rtl/bkl_duty_meas.sv]
// bkl_duty_meas: measures duty of the synchronised pwm input pin
// assumes: pwm_s already passed two flip-flops on clk_sys
`timescale 1ns/1ps
module bkl_duty_meas #(
    parameter int unsigned WIN_W = bkl_pkg::MEAS_WIN_W
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // pin level
    input  wire logic       pwm_s,
    // result
    output logic [7:0]      duty,
    output logic            active
);
    import bkl_pkg::*;

    logic [WIN_W-1:0] win_q, win_d;
    logic [WIN_W:0]   high_q, high_d;
    logic [7:0]       duty_q, duty_d;
    logic             act_q, act_d;

    always_comb
    begin
        win_d  = win_q + 1'b1;
        high_d = high_q + {{WIN_W{1'b0}}, pwm_s};
        duty_d = duty_q;
        act_d  = act_q;
        if (&win_q)
        begin
            // a window high on every cycle saturates to full duty
            duty_d = high_d[WIN_W] ? 8'hff : high_d[WIN_W-1 -: 8];
            act_d  = |high_d;
            high_d = '0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            win_q  <= '0;
            high_q <= '0;
            duty_q <= 8'h00;
            act_q  <= 1'b0;
        end
        else
        begin
            win_q  <= win_d;
            high_q <= high_d;
            duty_q <= duty_d;
            act_q  <= act_d;
        end
    end

    assign duty   = duty_q;
    assign active = act_q;
endmodule // bkl_duty_meas

// [rtl/bkl_i2c_slave.sv]
// bkl_i2c_slave: two-wire serial slave with auto-incrementing pointer
// assumes: scl and sda arrive from pins; register data answers in the same cycle
`timescale 1ns/1ps
module bkl_i2c_slave (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // serial pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_o,
    output logic            sda_oe,
    // register side
    output logic            wr_en,
    output logic            rd_en,
    output logic [7:0]      reg_addr,
    output logic [7:0]      wr_data,
    input  wire logic [7:0] rd_data
);
    import bkl_pkg::*;

    logic [2:0]  sync_q;
    logic [2:0]  sync2_q;
    logic        scl_s, sda_s, scl_p, sda_p;
    logic        start, stop, rise, fall;
    bkl_i2c_st_t st_q, st_d;
    logic [7:0]  sh_q, sh_d, ptr_q, ptr_d;
    logic [3:0]  bit_q, bit_d;
    logic        rw_q, rw_d, first_q, first_d;
    logic        oe_q, oe_d, more_q, more_d;

    assign scl_s = sync2_q[0];
    assign sda_s = sync2_q[1];
    assign scl_p = sync2_q[2];
    assign sda_p = sync_q[2];
    assign start = scl_s & scl_p & sda_p & ~sda_s;
    assign stop  = scl_s & scl_p & ~sda_p & sda_s;
    assign rise  = scl_s & ~scl_p;
    assign fall  = ~scl_s & scl_p;

    always_comb
    begin
        st_d = st_q;
        sh_d = sh_q;
        bit_d = bit_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        first_d = first_q;
        oe_d = oe_q;
        more_d = more_q;
        wr_en = 1'b0;
        rd_en = 1'b0;
        if (stop)
        begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
        end
        else if (start)
        begin
            st_d = ST_ADDR;
            bit_d = 4'h0;
            first_d = 1'b1;
            oe_d = 1'b0;
        end
        else
        begin
            case (st_q)
                ST_IDLE: st_d = ST_IDLE;
                ST_ADDR, ST_RXB:
                    if (rise)
                    begin
                        sh_d = {sh_q[6:0], sda_s};
                        bit_d = bit_q + 4'h1;
                    end
                    else if (fall && bit_q == 4'h8)
                    begin
                        oe_d = 1'b1;
                        if (st_q == ST_RXB)
                        begin
                            st_d = ST_RACK;
                            first_d = 1'b0;
                            ptr_d = first_q ? sh_q : ptr_q + 8'h01;
                            wr_en = ~first_q;
                        end
                        else if (sh_q[7:1] == SLAVE_ADDR)
                        begin
                            st_d = ST_AACK;
                            rw_d = sh_q[0];
                        end
                        else
                        begin
                            st_d = ST_IDLE;
                            oe_d = 1'b0;
                        end
                    end
                ST_AACK, ST_RACK:
                    if (fall)
                    begin
                        bit_d = 4'h0;
                        if (st_q == ST_AACK && rw_q)
                        begin
                            st_d = ST_TXB;
                            sh_d = rd_data;
                            rd_en = 1'b1;
                            oe_d = ~rd_data[7];
                        end
                        else
                        begin
                            st_d = ST_RXB;
                            oe_d = 1'b0;
                        end
                    end
                ST_TXB:
                    if (fall)
                    begin
                        if (bit_q == 4'h7)
                        begin
                            st_d = ST_TACK;
                            oe_d = 1'b0;
                        end
                        else
                        begin
                            sh_d = {sh_q[6:0], 1'b0};
                            oe_d = ~sh_q[6];
                            bit_d = bit_q + 4'h1;
                        end
                    end
                ST_TACK:
                    if (rise)
                    begin
                        more_d = ~sda_s;
                        ptr_d = sda_s ? ptr_q : ptr_q + 8'h01;
                    end
                    else if (fall)
                    begin
                        if (more_q)
                        begin
                            st_d = ST_TXB;
                            sh_d = rd_data;
                            rd_en = 1'b1;
                            oe_d = ~rd_data[7];
                            bit_d = 4'h0;
                        end
                        else
                            st_d = ST_IDLE;
                    end
                default: st_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        sync_q  <= {sda_s, sda_in, scl_in};
        sync2_q <= {scl_s, sync_q[1:0]};
        if (rst)
        begin
            st_q <= ST_IDLE;
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            oe_q <= 1'b0;
            more_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            first_q <= first_d;
            oe_q <= oe_d;
            more_q <= more_d;
        end
    end

    assign sda_o    = 1'b0;
    assign sda_oe   = oe_q;
    assign reg_addr = ptr_q;
    assign wr_data  = sh_q;
endmodule // bkl_i2c_slave

// [rtl/bkl_ctrl_regs.sv]
// bkl_ctrl_regs: register bank and brightness path of a led backlight driver
// assumes: pins from outside clk_sys; temperature and nvm status on clk_sys
`timescale 1ns/1ps
module bkl_ctrl_regs #(
    parameter int unsigned WIN_W    = bkl_pkg::MEAS_WIN_W,
    parameter logic        PANEL_ID = 1'b0,
    // arbitrary value
    parameter logic [3:0]  MAKER_ID = 4'h5,
    // arbitrary value
    parameter logic [2:0]  REV_ID   = 3'h1
) (
    // clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    // serial pins
    input  wire logic                       scl_in,
    input  wire logic                       sda_in,
    output logic                            sda_o,
    output logic                            sda_oe,
    // control pins
    input  wire logic                       pwm_in,
    input  wire logic                       en_in,
    // fault detectors
    input  wire logic                       led_open_det,
    input  wire logic                       led_short_det,
    input  wire logic                       overcurrent_det,
    input  wire logic                       thermal_det,
    input  wire logic                       low_supply_det,
    // fault pin, open drain
    output logic                            fault_o,
    output logic                            fault_oe,
    // backlight outputs
    output logic                            led_pwm,
    output logic                            chip_on,
    output logic [7:0]                      brightness_level,
    output logic [bkl_pkg::DIRECT_W-1:0]    channel_on,
    // temperature and nvm
    input  wire logic [bkl_pkg::TEMP_W-1:0] temp_code,
    input  wire logic                       nvm_idle,
    output logic                            nvm_init_cmd,
    output logic                            nvm_burn_cmd,
    output logic                            nvm_load_cmd
);
    import bkl_pkg::*;

    logic [6:0]          sync1_q, sync2_q;
    logic                pwm_s, en_s;
    logic [4:0]          det_s;
    logic                wr_en, rd_en;
    logic [7:0]          reg_addr, wr_data, rd_data;
    logic [7:0]          level_q, level_d;
    logic [7:0]          setup_q, setup_d;
    logic [7:0]          fault_q, fault_d;
    logic [7:0]          fault_set;
    logic                fault_clr;
    logic [DIRECT_W-1:0] direct_q, direct_d;
    logic [NVM_CMD_W-1:0] cmd_q, cmd_d;
    logic [7:0]          cnt_q;
    logic                pwm_q, pwm_d, on_q, on_d;
    logic [7:0]          meas_duty, duty_src;
    logic                meas_active;
    bkl_src_t            src;

    // pins pass two flops before use
    always_ff @(posedge clk_sys)
    begin
        sync1_q <= {pwm_in, en_in, led_open_det, led_short_det,
                    overcurrent_det, thermal_det, low_supply_det};
        sync2_q <= sync1_q;
    end
    assign pwm_s = sync2_q[6];
    assign en_s  = sync2_q[5];
    assign det_s = sync2_q[4:0];

    bkl_i2c_slave u_serial (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_o    (sda_o),
        .sda_oe   (sda_oe),
        .wr_en    (wr_en),
        .rd_en    (rd_en),
        .reg_addr (reg_addr),
        .wr_data  (wr_data),
        .rd_data  (rd_data)
    );

    bkl_duty_meas #(
        .WIN_W (WIN_W)
    ) u_meas (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pwm_s   (pwm_s),
        .duty    (meas_duty),
        .active  (meas_active)
    );

    // register writes and fault latching
    always_comb
    begin
        level_d  = level_q;
        setup_d  = setup_q;
        direct_d = direct_q;
        cmd_d    = '0;
        if (wr_en)
        begin
            case (reg_addr)
                ADDR_LEVEL:  level_d = wr_data;
                ADDR_SETUP:  setup_d = {5'h00, wr_data[SRC_LSB+SRC_W-1:0]};
                ADDR_DIRECT: direct_d = wr_data[DIRECT_LSB +: DIRECT_W];
                ADDR_NVM:    cmd_d = wr_data[NVM_CMD_W-1:0];
                default:     level_d = level_q;
            endcase
        end
        fault_set = 8'h00;
        fault_set[OPEN_BIT]   = det_s[4];
        fault_set[SHORT_BIT]  = det_s[3];
        fault_set[ANYLED_BIT] = det_s[4] | det_s[3];
        fault_set[OCP_BIT]    = det_s[2];
        fault_set[TSD_BIT]    = det_s[1];
        fault_set[LOW_SUPPLY_FLAG_BIT]   = det_s[0];
        fault_clr = (rd_en && reg_addr == ADDR_FAULT) || !en_s;
        // set wins over clear; flags hold otherwise
        fault_d = fault_set | (fault_q & ~{8{fault_clr}});
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            level_q  <= LEVEL_RST;
            setup_q  <= SETUP_RST;
            fault_q  <= FAULT_RST;
            direct_q <= DIRECT_RST[DIRECT_LSB +: DIRECT_W];
            cmd_q    <= '0;
        end
        else
        begin
            level_q  <= level_d;
            setup_q  <= setup_d;
            fault_q  <= fault_d;
            direct_q <= direct_d;
            cmd_q    <= cmd_d;
        end
    end

    // read mux; unmapped offsets read zero
    always_comb
    begin
        case (reg_addr)
            ADDR_LEVEL:   rd_data = level_q;
            ADDR_SETUP:   rd_data = setup_q;
            ADDR_FAULT:   rd_data = fault_q;
            ADDR_IDENT:   rd_data = {PANEL_ID, MAKER_ID, REV_ID};
            ADDR_DIRECT:  rd_data = {1'b0, direct_q, 1'b0};
            ADDR_TEMP_HI: rd_data = temp_code[TEMP_W-1:TEMP_LO_W];
            ADDR_TEMP_LO: rd_data = {temp_code[TEMP_LO_W-1:0], 5'h00};
            ADDR_NVM:     rd_data = {nvm_idle, 7'h00};
            default:      rd_data = 8'h00;
        endcase
    end

    // brightness path
    assign src = bkl_src_t'(setup_q[SRC_LSB +: SRC_W]);

    always_comb
    begin
        case (src)
            SRC_REG:
            begin
                duty_src = level_q;
                on_d = setup_q[ON_BIT];
            end
            default:
            begin
                duty_src = meas_duty;
                on_d = meas_active;
            end
        endcase
        if (src == SRC_PASS)
            pwm_d = pwm_s;
        else
            pwm_d = on_d && (cnt_q < duty_src);
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cnt_q <= 8'h00;
            pwm_q <= 1'b0;
            on_q  <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_q + 8'h01;
            pwm_q <= pwm_d;
            on_q  <= on_d;
        end
    end

    assign led_pwm          = pwm_q;
    assign chip_on          = on_q;
    assign brightness_level = duty_src;
    assign channel_on       = direct_q;
    assign nvm_init_cmd     = cmd_q[2];
    assign nvm_burn_cmd     = cmd_q[1];
    assign nvm_load_cmd     = cmd_q[0];
    assign fault_o          = 1'b0;
    assign fault_oe         = |fault_q;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    open_set_a: assert property (det_s[4] |=> fault_q[OPEN_BIT] && fault_oe)
        else $error("open fault not latched");
    short_set_a: assert property (det_s[3] |=> fault_q[SHORT_BIT] && fault_oe)
        else $error("short fault not latched");
    read_clear_a: assert property (
        (rd_en && reg_addr == ADDR_FAULT && det_s == 5'h00) |=> fault_q == 8'h00 && !fault_oe)
        else $error("fault read did not clear");
    pin_clear_a: assert property (
        (!en_s && det_s == 5'h00) ##1 (!en_s && det_s == 5'h00) |=> fault_q == 8'h00)
        else $error("enable low did not clear");
    flag_hold_a: assert property (
        (fault_q[OPEN_BIT] && en_s && !rd_en) |=> fault_q[OPEN_BIT])
        else $error("fault flag dropped");
    ro_write_a: assert property (
        (wr_en && reg_addr == ADDR_FAULT && !fault_clr && det_s == 5'h00)
        |=> $stable(fault_q))
        else $error("fault register changed by write");
    reset_zero_a: assert property (@(posedge clk_sys) disable iff (1'b0)
        rst |=> level_q == 8'h00 && setup_q == 8'h00 && fault_q == 8'h00)
        else $error("reset values wrong");
    reg_off_a: assert property (
        (src == SRC_REG && !setup_q[ON_BIT]) |=> !chip_on && !led_pwm)
        else $error("chip not off in register mode");
    reg_on_a: assert property (
        (src == SRC_REG && setup_q[ON_BIT]) |=> chip_on)
        else $error("chip not on in register mode");
    pin_mode_a: assert property (
        (!setup_q[SRC_LSB+1]) |=> chip_on == $past(meas_active))
        else $error("pin mode on state wrong");
    pass_thru_a: assert property ((src == SRC_PASS) |=> led_pwm == $past(pwm_s))
        else $error("pwm pass-through wrong");
    duty_edge_a: assert property (
        (src == SRC_REG && setup_q[ON_BIT] && cnt_q == level_q && level_q != 8'h00)
        ##1 1'b1 |-> led_pwm == 1'b0 ##1 $stable(level_q) || led_pwm == 1'b0)
        else $error("pwm duty edge wrong");
    pin_duty_a: assert property (
        (src == SRC_PIN_A && meas_active && cnt_q < meas_duty) |=> led_pwm)
        else $error("pin duty not followed");
    pin_wins_a: assert property (
        (!setup_q[SRC_LSB+1] && !meas_active) |=> !chip_on && !led_pwm)
        else $error("pin mode not off without pin activity");
    level_write_a: assert property (
        (wr_en && reg_addr == ADDR_LEVEL) |=> level_q == $past(wr_data))
        else $error("level write lost");
    setup_write_a: assert property (
        (wr_en && reg_addr == ADDR_SETUP) |=> setup_q[2:0] == $past(wr_data[2:0]))
        else $error("setup write lost");
    reg_level_a: assert property (
        (src == SRC_REG) |-> brightness_level == level_q)
        else $error("register level not used");
    pin_level_a: assert property (
        (src != SRC_REG) |-> brightness_level == meas_duty)
        else $error("pin duty not used");
    any_led_a: assert property (
        (det_s[4] || det_s[3]) |=> fault_q[ANYLED_BIT])
        else $error("led fault summary not latched");
    short_hold_a: assert property (
        (fault_q[SHORT_BIT] && en_s && !rd_en) |=> fault_q[SHORT_BIT])
        else $error("short flag dropped");
    pin_release_a: assert property (
        (fault_q == 8'h00) |-> !fault_oe)
        else $error("fault pin not released");


    read_fault_c: cover property (fault_q[OPEN_BIT] ##[1:1000] (fault_q == 8'h00));
    reg_mode_c: cover property (src == SRC_REG && chip_on ##1 led_pwm);
    pass_mode_c: cover property (src == SRC_PASS && led_pwm);
    pin_b_c: cover property (src == SRC_PIN_B && chip_on);
    short_read_c: cover property (fault_q[SHORT_BIT] ##[1:1000] !fault_oe);
endmodule // bkl_ctrl_regs

// [bench/bkl_host.sv]
// bkl_host: two-wire host model driving the serial clock and data pins
// assumes: the bench resolves sda from both drivers with a pull-up
`timescale 1ns/1ps
module bkl_host (
    // clock
    input  wire logic clk_sys,
    // serial pins
    input  wire logic sda_w,
    output logic      scl,
    output logic      sda_d
);
    int n_nack = 0;
    initial
    begin
        scl = 1'b1;
        sda_d = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // data moves only while scl is low, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        w(2);
        sda_d <= b;
        w(8);
        scl <= 1'b1;
        w(5);
        r = sda_w;
        w(5);
        scl <= 1'b0;
    endtask
    task automatic start;
        w(2);
        sda_d <= 1'b1;
        w(4);
        scl <= 1'b1;
        w(8);
        sda_d <= 1'b0;
        w(8);
        scl <= 1'b0;
    endtask
    task automatic stop;
        w(2);
        sda_d <= 1'b0;
        w(8);
        scl <= 1'b1;
        w(8);
        sda_d <= 1'b1;
        w(8);
    endtask
    // msb first, then the acknowledge bit
    task automatic xbyte(input logic [7:0] d, input logic ab, output logic [7:0] q,
                         output logic a);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ab, a);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic [7:0] q;
        logic       a;
        start();
        xbyte({bkl_pkg::SLAVE_ADDR, 1'b0}, 1'b1, q, a);
        n_nack += int'(a);
        xbyte(p, 1'b1, q, a);
        n_nack += int'(a);
        xbyte(d, 1'b1, q, a);
        n_nack += int'(a);
        stop();
    endtask
    // pointer write, repeated start, one byte read and refused with nack
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic [7:0] q;
        logic       a;
        start();
        xbyte({bkl_pkg::SLAVE_ADDR, 1'b0}, 1'b1, q, a);
        n_nack += int'(a);
        xbyte(p, 1'b1, q, a);
        n_nack += int'(a);
        start();
        xbyte({bkl_pkg::SLAVE_ADDR, 1'b1}, 1'b1, q, a);
        n_nack += int'(a);
        xbyte(8'hff, 1'b1, d, a);
        stop();
    endtask
endmodule // bkl_host

// [bench/testbench.sv]
// testbench: self-checking bench for the backlight control register bank
// assumes: bkl_host drives the serial pins; sda and fault pins have pull-ups
`timescale 1ns/1ps
module testbench;
    import bkl_pkg::*;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       pwm_in = 1'b0;
    logic       en_in = 1'b1;
    logic       lo = 1'b0;
    logic       ls = 1'b0;
    logic       scl;
    logic       sda_d;
    logic       sda_oe;
    logic       fault_oe;
    logic       led_pwm;
    logic       chip_on;
    logic [2:0] h = 3'h0;
    logic [7:0] brightness_level;
    logic [7:0] q;
    logic [7:0] lv;
    logic [TEMP_W-1:0] tc = '0;
    logic [DIRECT_W-1:0] ch;
    wire  [2:0] nv;
    logic [2:0] nv_seen = 3'h0;
    wire        sda_w = sda_d & ~sda_oe;
    int         n_fail = 0;
    int         n_compared = 0;
    int         k;
    int         c;
    always #12.5 clk_sys = ~clk_sys;
    bkl_ctrl_regs #(.WIN_W(8)) DUT (
        .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda_w), .sda_o(),
        .sda_oe(sda_oe), .pwm_in(pwm_in), .en_in(en_in), .led_open_det(lo),
        .led_short_det(ls), .overcurrent_det(1'b0), .thermal_det(1'b0),
        .low_supply_det(1'b0), .fault_o(), .fault_oe(fault_oe), .led_pwm(led_pwm),
        .chip_on(chip_on), .brightness_level(brightness_level), .channel_on(ch),
        .temp_code(tc), .nvm_idle(1'b1), .nvm_init_cmd(nv[2]), .nvm_burn_cmd(nv[1]),
        .nvm_load_cmd(nv[0]));
    always @(posedge clk_sys)
    begin
        if (|nv)
            nv_seen <= nv;
    end
    bkl_host host (.clk_sys(clk_sys), .sda_w(sda_w), .scl(scl), .sda_d(sda_d));
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // open or short pulse, then fault pin and fault byte
    task automatic fault(input logic op, input logic [7:0] exp);
        lo <= op;
        ls <= ~op;
        w(3);
        lo <= 1'b0;
        ls <= 1'b0;
        w(8);
        @(negedge clk_sys);
        chk(fault_oe, 1'b1);
        host.wr(ADDR_FAULT, 8'h00);
        host.rd(ADDR_FAULT, q);
        chk(q, exp);
        chk(fault_oe, 1'b0);
        host.rd(ADDR_FAULT, q);
        chk(q, 8'h00);
    endtask
    initial
    begin
        void'($urandom(32'ha4e2));
        w(2);
        rst <= 1'b0;
        w(2);
        for (k = 0; k < 3; k++)
        begin
            host.rd(8'(k), q);
            chk(q, 8'h00);
        end
        host.wr(ADDR_IDENT, 8'h00);
        host.rd(ADDR_IDENT, q);
        chk(q, {1'b0, 4'h5, 3'h1});
        host.rd(8'h10, q);
        chk(q, 8'h00);
        tc <= 11'($urandom);
        lv = 8'($urandom);
        host.wr(ADDR_DIRECT, lv);
        chk({2'b00, ch}, {2'b00, lv[6:1]});
        host.rd(ADDR_DIRECT, q);
        chk(q, {1'b0, lv[6:1], 1'b0});
        host.rd(ADDR_TEMP_HI, q);
        chk(q, tc[10:3]);
        host.rd(ADDR_TEMP_LO, q);
        chk(q, {tc[2:0], 5'h00});
        host.wr(ADDR_NVM, 8'h05);
        chk({5'h00, nv_seen}, 8'h05);
        host.rd(ADDR_NVM, q);
        chk(q, 8'h80);
        host.wr(ADDR_SETUP, 8'h05);
        for (k = 0; k < 3; k++)
        begin
            lv = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom_range(1, 254));
            host.wr(ADDR_LEVEL, lv);
            pwm_in <= ~pwm_in;
            w(4);
            @(negedge clk_sys);
            chk(chip_on, 1'b1);
            chk(brightness_level, lv);
            c = 0;
            repeat (256)
            begin
                @(negedge clk_sys);
                c += int'(led_pwm);
            end
            chk(8'(c), lv);
        end
        host.wr(ADDR_SETUP, 8'h04);
        w(4);
        @(negedge clk_sys);
        chk(chip_on, 1'b0);
        host.wr(ADDR_SETUP, 8'h06);
        for (k = 0; k < 40; k++)
        begin
            @(posedge clk_sys);
            pwm_in <= 1'($urandom);
            h <= {h[1:0], pwm_in};
            @(negedge clk_sys);
            if (k > 4)
                chk(led_pwm, h[2]);
        end
        for (k = 0; k < 2; k++)
        begin
            host.wr(ADDR_SETUP, 8'(k * 3));
            pwm_in <= 1'b0;
            w(600);
            @(negedge clk_sys);
            chk(chip_on, 1'b0);
            chk(brightness_level, 8'h00);
            @(posedge clk_sys);
            pwm_in <= 1'b1;
            w(600);
            @(negedge clk_sys);
            chk(chip_on, 1'b1);
            chk(brightness_level, 8'hff);
        end
        fault(1'b1, 8'h88);
        fault(1'b0, 8'h48);
        lo <= 1'b1;
        w(3);
        lo <= 1'b0;
        w(6);
        @(negedge clk_sys);
        chk(fault_oe, 1'b1);
        @(posedge clk_sys);
        en_in <= 1'b0;
        w(4);
        en_in <= 1'b1;
        w(4);
        @(negedge clk_sys);
        chk(fault_oe, 1'b0);
        chk(8'(host.n_nack), 8'h00);
        end_sim();
    end
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        n_fail++;
        end_sim();
    end
endmodule // testbench
